/* File: hw/can_id_classify.sv */
`timescale 1ns/1ns
`default_nettype none
`include "canopen_nmt_cfg.svh"

// Splits an identifier into function code and node number and classifies it.
module can_id_classify
  import canopen_nmt_pkg::*;
(
  input wire logic [10:0] id_i,
  input wire logic [6:0] node_i,
  output frame_kind_t kind_o,
  output logic to_me_o
);

  logic [3:0] fc;  // Function code field.
  logic [6:0] nn;  // Node number field.
  logic bcast;     // Node field is zero.

  assign fc = id_i[`FC_HI:`FC_LO];
  assign nn = id_i[`NODE_HI:`NODE_LO];
  assign bcast = (nn == `NODE_BROADCAST);
  // Point-to-point frames count only with a valid own node number.
  assign to_me_o = (nn == node_i) && (node_i != `NODE_BROADCAST);

  // Maps the function code to a frame class.
  always_comb begin
    kind_o = FK_OTHER;
    unique case (fc)
      `FC_NMT: kind_o = bcast ? FK_NMT : FK_OTHER;
      `FC_SYNC_EMCY: kind_o = bcast ? FK_SYNC : FK_EMCY;
      `FC_TIME: kind_o = bcast ? FK_TIME : FK_OTHER;
      `FC_RPDO1: kind_o = FK_RPDO1;
      `FC_RPDO2: kind_o = FK_RPDO2;
      `FC_RPDO3, `FC_RPDO4: kind_o = FK_RPDO_UNSUP;
      `FC_SDO_RX: kind_o = FK_SDO_RX;
      default: kind_o = FK_OTHER;
    endcase
  end

endmodule
`default_nettype wire

/* File: hw/can_tx_id_build.sv */
`timescale 1ns/1ns
`default_nettype none
`include "canopen_nmt_cfg.svh"

// Builds the outgoing identifier from frame class and own node number.
module can_tx_id_build
  import canopen_nmt_pkg::*;
(
  input wire tx_kind_t kind_i,
  input wire logic [6:0] node_i,
  output logic [10:0] id_o
);

  logic [3:0] fc;  // Function code for the class.

  // Selects the function code of each sent class.
  always_comb begin
    fc = `FC_ERR_CTRL;
    unique case (kind_i)
      TX_BOOT, TX_ERR_CTRL: fc = `FC_ERR_CTRL;
      TX_EMCY: fc = `FC_SYNC_EMCY;
      TX_SDO: fc = `FC_SDO_TX;
      TX_TPDO1: fc = `FC_TPDO1;
      TX_TPDO2: fc = `FC_TPDO2;
    endcase
  end

  assign id_o = {fc, node_i};

endmodule
`default_nettype wire

/* File: hw/canopen_nmt_cfg.svh */
`ifndef CANOPEN_NMT_CFG_SVH
`define CANOPEN_NMT_CFG_SVH

// Identifier field positions.
`define ID_W 11
`define FC_HI 10
`define FC_LO 7
`define NODE_HI 6
`define NODE_LO 0
`define NODE_BROADCAST 7'h00

// Function codes of the predefined connection set.
`define FC_NMT 4'h0
`define FC_SYNC_EMCY 4'h1
`define FC_TIME 4'h2
`define FC_TPDO1 4'h3
`define FC_RPDO1 4'h4
`define FC_TPDO2 4'h5
`define FC_RPDO2 4'h6
`define FC_TPDO3 4'h7
`define FC_RPDO3 4'h8
`define FC_TPDO4 4'h9
`define FC_RPDO4 4'ha
`define FC_SDO_TX 4'hb
`define FC_SDO_RX 4'hc
`define FC_ERR_CTRL 4'he

// Network command values.
`define CMD_START 8'h01
`define CMD_STOP 8'h02
`define CMD_PREOP 8'h80
`define CMD_RESET_NODE 8'h81
`define CMD_RESET_COMM 8'h82

// State codes carried in error-control frames.
`define HB_BOOT 8'h00
`define HB_STOPPED 8'h04
`define HB_OPER 8'h05
`define HB_PREOP 8'h7f

// Cycles spent in each self-timed state.
`define CNT_W 8
`define INIT_CYCLES 8'h10
`define RST_APP_CYCLES 8'h10
`define RST_COMM_CYCLES 8'h10
`define CNT_ONE 8'h01
`define CNT_ZERO 8'h00

`endif

/* File: hw/canopen_nmt_pkg.sv */
package canopen_nmt_pkg;

  // Network-management state of the node.
  typedef enum logic [2:0] {
    NS_INIT,
    NS_PREOP,
    NS_OPER,
    NS_STOPPED,
    NS_RST_APP,
    NS_RST_COMM
  } nmt_state_t;

  // Class of a received frame.
  typedef enum logic [3:0] {
    FK_NMT,
    FK_SYNC,
    FK_EMCY,
    FK_TIME,
    FK_RPDO1,
    FK_RPDO2,
    FK_RPDO_UNSUP,
    FK_SDO_RX,
    FK_OTHER
  } frame_kind_t;

  // Class of a frame the node sends.
  typedef enum logic [2:0] {
    TX_BOOT,
    TX_EMCY,
    TX_SDO,
    TX_TPDO1,
    TX_TPDO2,
    TX_ERR_CTRL
  } tx_kind_t;

endpackage

/* File: hw/canopen_nmt_slave_id_decode.sv */
`timescale 1ns/1ns
`default_nettype none
`include "canopen_nmt_cfg.svh"

// Network-management slave: frame classification, node state, send gating.
module canopen_nmt_slave_id_decode
  import canopen_nmt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [6:0] node_pins_i,
  input wire logic rx_valid_i,
  input wire logic [10:0] rx_id_i,
  input wire logic [7:0] rx_cmd_i,
  input wire logic [7:0] rx_target_i,
  input wire logic emcy_req_i,
  input wire logic sdo_req_i,
  input wire logic [1:0] tpdo_req_i,
  input wire logic err_ctrl_req_i,
  input wire logic tx_ready_i,
  output nmt_state_t nmt_state_o,
  output logic [6:0] node_id_o,
  output logic sync_o,
  output logic [1:0] rpdo_o,
  output logic sdo_rx_o,
  output logic rx_drop_o,
  output logic tx_valid_o,
  output logic [10:0] tx_id_o,
  output logic [7:0] tx_byte0_o,
  output tx_kind_t tx_kind_o,
  output logic tx_done_o
);

  nmt_state_t state_q;          // Current network-management state.
  logic [`CNT_W-1:0] cnt_q;     // Cycles left in a self-timed state.
  logic [6:0] pins_meta_q;      // First synchroniser stage for node pins.
  logic [6:0] pins_sync_q;      // Second synchroniser stage for node pins.
  logic [6:0] node_q;           // Node number latched at end of init.
  logic boot_pend_q;            // Boot-up frame still owed.
  frame_kind_t kind;            // Class of the frame on the receive port.
  logic to_me;                  // Receive identifier carries our node.
  logic cmd_hit;                // A command frame is addressed to us.
  logic cnt_end;                // Self-timed state has run out.
  logic tx_fire;                // Current send is taken this cycle.
  tx_kind_t pick_kind;          // Class of the next send.
  logic pick_ok;                // A gated request is waiting.
  logic [10:0] pick_id;         // Identifier for the next send.
  logic pre_or_op;              // Pre-operational or operational.

  // Receive identifier classifier.
  // It sees the latched node number, so the straps cannot move it mid-frame.
  can_id_classify u_classify (
    .id_i(rx_id_i),
    .node_i(node_q),
    .kind_o(kind),
    .to_me_o(to_me)
  );

  // Transmit identifier builder.
  // It uses the same node number, so sent and received identifiers agree.
  can_tx_id_build u_build (
    .kind_i(pick_kind),
    .node_i(node_q),
    .id_o(pick_id)
  );

  // Shared conditions used by several processes below.
  // A frame leaves the port at the edge where valid and ready are both high.
  assign pre_or_op = (state_q == NS_PREOP) || (state_q == NS_OPER);
  assign cnt_end = (cnt_q == `CNT_ZERO);
  assign tx_fire = tx_valid_o && tx_ready_i;

  // Node pins come from outside, so pass them through two flops.
  // Only the second stage is read, so a strap that changes near an edge
  // can never reach the node number half settled.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pins_meta_q <= 7'h00;
      pins_sync_q <= 7'h00;
    end else begin
      pins_meta_q <= node_pins_i;
      pins_sync_q <= pins_meta_q;
    end
  end

  // A command counts only from pre-operational, operational or stopped.
  // The target byte is compared whole, so a set top bit never matches.
  // The init and reset states ignore commands, which keeps their counts intact.
  always_comb begin
    cmd_hit = 1'b0;
    if (rx_valid_i && (kind == FK_NMT)) begin
      if (pre_or_op || (state_q == NS_STOPPED)) begin
        cmd_hit = (rx_target_i == {1'b0, node_q}) || (rx_target_i == {1'b0, `NODE_BROADCAST});
      end
    end
  end

  // Main state machine; only the counter and commands move it.
  // Init waits for its boot-up frame to be taken before leaving.
  // state ownership
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q <= NS_INIT;
    end else begin
      unique case (state_q)
        NS_INIT: begin
          if (cnt_end && !boot_pend_q) begin
            state_q <= NS_PREOP;
          end
        end
        NS_RST_APP: begin
          if (cnt_end) begin
            state_q <= NS_RST_COMM;
          end
        end
        NS_RST_COMM: begin
          if (cnt_end) begin
            state_q <= NS_INIT;
          end
        end
        NS_PREOP, NS_OPER, NS_STOPPED: begin
          // Commands act only here; the same command twice is harmless.
          if (cmd_hit) begin
            unique case (rx_cmd_i)
              `CMD_START: state_q <= NS_OPER;
              `CMD_STOP: state_q <= NS_STOPPED;
              `CMD_PREOP: state_q <= NS_PREOP;
              `CMD_RESET_NODE: state_q <= NS_RST_APP;
              `CMD_RESET_COMM: state_q <= NS_RST_COMM;
              default: state_q <= state_q;
            endcase
          end
        end
        default: begin
          // A corrupted code falls back to init without a counter reload, so a zero count leaves init at once with no boot-up frame.
          state_q <= NS_INIT;
        end
      endcase
    end
  end

  // Reloads the counter on entry to each self-timed state.
  // The exit reloads come first, so a state that ends hands over a full count.
  // Outside the timed states the count rests at zero and costs nothing.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cnt_q <= `INIT_CYCLES;
    end else if ((state_q == NS_RST_APP) && cnt_end) begin
      cnt_q <= `RST_COMM_CYCLES;
    end else if ((state_q == NS_RST_COMM) && cnt_end) begin
      cnt_q <= `INIT_CYCLES;
    end else if (cmd_hit && (rx_cmd_i == `CMD_RESET_NODE)) begin
      cnt_q <= `RST_APP_CYCLES;
    end else if (cmd_hit && (rx_cmd_i == `CMD_RESET_COMM)) begin
      cnt_q <= `RST_COMM_CYCLES;
    end else if (!cnt_end) begin
      cnt_q <= cnt_q - `CNT_ONE;
    end
  end

  // Latches the node number and arms the boot-up frame as init finishes.
  // The straps are read once per init, so a change while running waits for a reset.
  // The set and the clear never meet: the clear needs a boot-up frame already out.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      node_q <= `NODE_BROADCAST;
      boot_pend_q <= 1'b0;
    end else if ((state_q == NS_INIT) && (cnt_q == `CNT_ONE)) begin
      node_q <= pins_sync_q;
      boot_pend_q <= 1'b1;
    end else if (tx_fire && (tx_kind_o == TX_BOOT)) begin
      boot_pend_q <= 1'b0;
    end
  end

  // Receive events, one-cycle pulses, gated by state except the drop pulse.
  // Each pulse follows its frame by one cycle, so a frame every cycle is fine.
  // Frames for other nodes leave every pulse low.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sync_o <= 1'b0;
      rpdo_o <= 2'b00;
      sdo_rx_o <= 1'b0;
      rx_drop_o <= 1'b0;
    end else begin
      sync_o <= rx_valid_i && (kind == FK_SYNC) && pre_or_op;
      rpdo_o[0] <= rx_valid_i && (kind == FK_RPDO1) && to_me && (state_q == NS_OPER);
      rpdo_o[1] <= rx_valid_i && (kind == FK_RPDO2) && to_me && (state_q == NS_OPER);
      sdo_rx_o <= rx_valid_i && (kind == FK_SDO_RX) && to_me && pre_or_op;
      rx_drop_o <= rx_valid_i && ((kind == FK_TIME) || ((kind == FK_RPDO_UNSUP) && to_me));
    end
  end

  // Picks the next send by fixed priority among requests the state allows.
  // A request the state forbids simply waits; it is neither queued nor lost.
  // Boot-up comes first so that init can finish as early as possible.
  always_comb begin
    pick_ok = 1'b0;
    pick_kind = TX_ERR_CTRL;
    if (boot_pend_q && (state_q == NS_INIT)) begin
      pick_ok = 1'b1;
      pick_kind = TX_BOOT;
    end else if (emcy_req_i && pre_or_op) begin
      pick_ok = 1'b1;
      pick_kind = TX_EMCY;
    end else if (sdo_req_i && pre_or_op) begin
      pick_ok = 1'b1;
      pick_kind = TX_SDO;
    end else if (tpdo_req_i[0] && (state_q == NS_OPER)) begin
      pick_ok = 1'b1;
      pick_kind = TX_TPDO1;
    end else if (tpdo_req_i[1] && (state_q == NS_OPER)) begin
      pick_ok = 1'b1;
      pick_kind = TX_TPDO2;
    end else if (err_ctrl_req_i && (pre_or_op || (state_q == NS_STOPPED))) begin
      pick_ok = 1'b1;
      pick_kind = TX_ERR_CTRL;
    end
  end

  // Send port: holds a frame until taken, then pulses done.
  // A frame in flight is never withdrawn, even when the state moves on.
  // The state code byte is captured at load and matches the moment of loading.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tx_valid_o <= 1'b0;
      tx_id_o <= 11'h000;
      tx_byte0_o <= 8'h00;
      tx_kind_o <= TX_BOOT;
      tx_done_o <= 1'b0;
    end else begin
      tx_done_o <= tx_fire;
      if (tx_fire) begin
        tx_valid_o <= 1'b0;
      end else if (!tx_valid_o && !tx_done_o && pick_ok) begin
        // The gap after done lets the requester drop its request.
        tx_valid_o <= 1'b1;
        tx_id_o <= pick_id;
        tx_kind_o <= pick_kind;
        // The first data byte carries the state code for error control.
        unique case (state_q)
          NS_OPER: tx_byte0_o <= `HB_OPER;
          NS_PREOP: tx_byte0_o <= `HB_PREOP;
          NS_STOPPED: tx_byte0_o <= `HB_STOPPED;
          default: tx_byte0_o <= `HB_BOOT;
        endcase
      end
    end
  end

  // State and node number outputs.
  // Both lag the internal registers by one cycle so that every output is a flop.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      nmt_state_o <= NS_INIT;
      node_id_o <= `NODE_BROADCAST;
    end else begin
      nmt_state_o <= state_q;
      node_id_o <= node_q;
    end
  end

endmodule
`default_nettype wire

/* File: tb/can_master_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Network master and CAN controller facing the slave.
module can_master_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic tx_valid_i,
  input wire logic [10:0] tx_id_i,
  input wire logic [7:0] tx_byte0_i,
  output logic rx_valid_o,
  output logic [10:0] rx_id_o,
  output logic [7:0] rx_cmd_o,
  output logic [7:0] rx_target_o,
  output logic tx_ready_o,
  output logic [10:0] last_id_o,
  output logic [7:0] last_byte0_o
);
  // No frame at start.
  initial begin
    rx_valid_o = 1'b0;
    rx_id_o = 11'h7ff;
    rx_cmd_o = 8'h00;
    rx_target_o = 8'h00;
    tx_ready_o = 1'b0;
  end
  // Takes frames at once, or stalls at random when slow.
  always @(posedge clk_i) begin
    tx_ready_o <= slow_i ? 1'($urandom_range(1)) : 1'b1;
    if (tx_valid_i && tx_ready_o) begin
      last_id_o <= tx_id_i;
      last_byte0_o <= tx_byte0_i;
    end
  end
  task automatic send(input logic [10:0] id, input logic [7:0] cmd, input logic [7:0] tgt);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_id_o <= id;
    rx_cmd_o <= cmd;
    rx_target_o <= tgt;
    @(posedge clk_i);
    // Released lines show the inverse of the last frame.
    rx_valid_o <= 1'b0;
    rx_id_o <= ~id;
    rx_cmd_o <= ~cmd;
    rx_target_o <= ~tgt;
  endtask
endmodule
`default_nettype wire

/* File: tb/canopen_nmt_slave_id_decode_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// Bench: boot, frame classes, send requests, random commands.
module canopen_nmt_slave_id_decode_tb;
  import canopen_nmt_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [6:0] node_pins_i = 7'h01;
  logic emcy_req_i = 1'b0;
  logic sdo_req_i = 1'b0;
  logic [1:0] tpdo_req_i = 2'b00;
  logic err_ctrl_req_i = 1'b0;
  logic slow = 1'b0;
  logic rx_valid_i, tx_ready_i, sync_o, sdo_rx_o, rx_drop_o, tx_valid_o, tx_done_o;
  logic [10:0] rx_id_i, tx_id_o, last_id;
  logic [7:0] rx_cmd_i, rx_target_i, tx_byte0_o, last_b0, tgt;
  logic [6:0] node_id_o, node;
  logic [1:0] rpdo_o;
  nmt_state_t nmt_state_o, st;
  tx_kind_t tx_kind_o;
  // Test frames with their pulse patterns, function codes, commands.
  logic [10:0] ids [9];
  logic [4:0] exps [9];
  logic [3:0] fc [5];
  logic [7:0] cmds [6];
  int n_fail = 0;
  int checks = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  canopen_nmt_slave_id_decode uut (.*);
  can_master_model u_m (.clk_i(ref_clk_i), .slow_i(slow), .tx_valid_i(tx_valid_o), .tx_id_i(tx_id_o),
    .tx_byte0_i(tx_byte0_o), .rx_valid_o(rx_valid_i), .rx_id_o(rx_id_i), .rx_cmd_o(rx_cmd_i),
    .rx_target_o(rx_target_i), .tx_ready_o(tx_ready_i), .last_id_o(last_id), .last_byte0_o(last_b0));
  // Counts a comparison and reports a difference.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Prints counts and verdict, then ends the run.
  task automatic stop_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // State after a command that this node obeys.
  function automatic nmt_state_t next_st(input nmt_state_t s, input logic [7:0] v);
    case (v)
      8'h01: next_st = NS_OPER;
      8'h02: next_st = NS_STOPPED;
      8'h80: next_st = NS_PREOP;
      8'h81: next_st = NS_RST_APP;
      8'h82: next_st = NS_RST_COMM;
      default: next_st = s;
    endcase
  endfunction
  // Waits, bounded, for pre-operational and checks the boot-up frame.
  task automatic wait_preop();
    int i;
    for (i = 0; i < 300 && nmt_state_o !== NS_PREOP; i++) begin
      @(posedge ref_clk_i);
    end
    check(16'(i < 300), 16'h1);
    if (i == 300) begin
      stop_test();
    end
    check(last_id, {4'he, node});
    check(last_b0, 8'h00);
    st = NS_PREOP;
  endtask
  // Sends a frame and checks the pulses that follow it.
  task automatic rx(input logic [10:0] id, input logic [4:0] exp);
    u_m.send(id, 8'($urandom), 8'($urandom));
    #1 check({sync_o, rpdo_o, sdo_rx_o, rx_drop_o}, exp);
  endtask
  // Sends a command and checks the state two edges later.
  task automatic cmd(input logic [7:0] v, input logic [7:0] t);
    u_m.send(11'h000, v, t);
    if (t == 8'h00 || t == {1'b0, node}) begin
      st = next_st(st, v);
    end
    repeat (2) @(posedge ref_clk_i);
    #1 check(nmt_state_o, st);
    if (st == NS_RST_APP || st == NS_RST_COMM) begin
      wait_preop();
    end
  endtask
  // Raises one request level and expects a frame or none.
  task automatic tx(input int k, input logic go, input logic [7:0] b0);
    int i;
    @(posedge ref_clk_i);
    {err_ctrl_req_i, tpdo_req_i, sdo_req_i, emcy_req_i} <= 5'(1 << k);
    for (i = 0; i < 30; i++) begin
      @(posedge ref_clk_i);
      if (tx_valid_o && tx_ready_i) break;
    end
    {err_ctrl_req_i, tpdo_req_i, sdo_req_i, emcy_req_i} <= 5'h00;
    check(16'(i < 30), 16'(go));
    if (go && i == 30) begin
      stop_test();
    end
    if (go) begin
      check(tx_id_o, {fc[k], node});
      check(tx_kind_o, 16'(k + 1));
      if (k == 4) check(tx_byte0_o, b0);
      // Done stands only in the cycle after the taking edge.
      #1 check(tx_done_o, 1'b1);
      @(posedge ref_clk_i);
      #1 check(tx_done_o, 1'b0);
    end
  endtask
  initial begin
    int i;
    void'($urandom(18));
    node = 7'($urandom_range(127, 1));
    node_pins_i <= node;
    fc = '{4'h1, 4'hb, 4'h3, 4'h5, 4'he};
    cmds = '{8'h01, 8'h02, 8'h80, 8'h81, 8'h82, 8'h03};
    ids = '{{4'h4, node}, {4'h6, node}, {4'h8, node}, {4'ha, node}, 11'h100, {4'hc, node}, 11'h080,
      {4'h4, node ^ 7'h01}, {4'h1, node}};
    exps = '{5'h04, 5'h08, 5'h01, 5'h01, 5'h01, 5'h02, 5'h10, 5'h00, 5'h00};
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 check(nmt_state_o, NS_INIT);
    // A start command in init is ignored.
    u_m.send(11'h000, 8'h01, 8'h00);
    wait_preop();
    check(node_id_o, node);
    rx(ids[0], 5'h00);
    for (i = 0; i < 5; i++) begin
      tx(i, i != 2 && i != 3, 8'h7f);
    end
    cmd(8'h01, 8'h00);
    for (i = 0; i < 9; i++) begin
      rx(ids[i], exps[i]);
    end
    for (i = 0; i < 5; i++) begin
      tx(i, 1'b1, 8'h05);
    end
    // Random commands and targets, prompt then slow controller.
    for (i = 0; i < 40; i++) begin
      slow <= i >= 20;
      tgt = ($urandom_range(2) == 0) ? 8'h00 : {1'b0, node ^ 7'($urandom_range(1))};
      cmd(cmds[$urandom_range(5)], tgt);
      if (st == NS_STOPPED) begin
        tx(4, 1'b1, 8'h04);
        tx(0, 1'b0, 8'h00);
      end
    end
    stop_test();
  end
endmodule
`default_nettype wire

/* File: tb/nmt_slave_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// Checks state moves and sent identifiers at the slave's ports.
module nmt_slave_monitor
  import canopen_nmt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic rx_valid_i,
  input wire logic [10:0] rx_id_i,
  input wire logic [7:0] rx_cmd_i,
  input wire logic [7:0] rx_target_i,
  input wire nmt_state_t nmt_state_o,
  input wire logic [6:0] node_id_o,
  input wire logic [1:0] rpdo_o,
  input wire logic tx_valid_o,
  input wire logic [10:0] tx_id_o,
  input wire tx_kind_t tx_kind_o
);
  default clocking mon_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  // Frame in the last cycle, so the state output may lag it.
  logic prev_q;
  // Command for this node while the state output is settled.
  logic cmd;
  // Remembers whether a frame arrived one cycle ago.
  always_ff @(posedge ref_clk_i) begin
    prev_q <= rx_valid_i;
  end
  assign cmd = rx_valid_i && !prev_q && rx_id_i == 11'h000 &&
    (rx_target_i == 8'h00 || rx_target_i == {1'b0, node_id_o});
  AST_INIT: assert property (
    $fell(reset_i) |-> nmt_state_o == NS_INIT && !tx_valid_o) else $error("not init after reset");
  AST_START: assert property (
    cmd && rx_cmd_i == 8'h01 && nmt_state_o inside {NS_PREOP, NS_STOPPED} |-> ##2 nmt_state_o == NS_OPER)
    else $error("start not obeyed");
  AST_STOP: assert property (
    cmd && rx_cmd_i == 8'h02 && nmt_state_o inside {NS_PREOP, NS_OPER} |-> ##2 nmt_state_o == NS_STOPPED)
    else $error("stop not obeyed");
  AST_PREOP: assert property (
    cmd && rx_cmd_i == 8'h80 && nmt_state_o inside {NS_OPER, NS_STOPPED} |-> ##2 nmt_state_o == NS_PREOP)
    else $error("preop not obeyed");
  AST_RST_NODE: assert property (
    cmd && rx_cmd_i == 8'h81 && nmt_state_o inside {NS_PREOP, NS_OPER, NS_STOPPED}
    |-> ##2 nmt_state_o == NS_RST_APP) else $error("reset node not obeyed");
  AST_RST_COMM: assert property (
    cmd && rx_cmd_i == 8'h82 && nmt_state_o inside {NS_PREOP, NS_OPER, NS_STOPPED}
    |-> ##2 nmt_state_o == NS_RST_COMM) else $error("reset comm not obeyed");
  AST_AUTO_APP: assert property (
    nmt_state_o == NS_RST_APP |-> ##[1:40] nmt_state_o == NS_RST_COMM) else $error("stuck in reset app");
  AST_AUTO_COMM: assert property (
    nmt_state_o == NS_RST_COMM |-> ##[1:40] nmt_state_o == NS_INIT) else $error("stuck in reset comm");
  AST_PDO_GATE: assert property (
    rpdo_o != 2'b00 |-> nmt_state_o == NS_OPER) else $error("process data outside operational");
  AST_RPDO_ID: assert property (
    rpdo_o[0] |-> $past(rx_id_i) == {4'h4, node_id_o}) else $error("wrong channel one id");
  AST_TX_ID: assert property (
    tx_valid_o && tx_kind_o inside {TX_BOOT, TX_ERR_CTRL} |-> tx_id_o == {4'he, node_id_o})
    else $error("wrong error control id");
  AST_BOOT: assert property (
    tx_valid_o && tx_kind_o == TX_BOOT |-> nmt_state_o == NS_INIT) else $error("boot-up outside init");
endmodule

bind canopen_nmt_slave_id_decode nmt_slave_monitor u_mon (.*);
`default_nettype wire
